// ===== hw/chan_status_pkg.sv
// Purpose: Shared constants and types for the channel discovery and power status bank
// Assumes: Four channels per group, byte-wide registers on the serial management port
// Notes: Encodings of the requested-class and detection fields live here
package chan_status_pkg;

   localparam int NUM_CH = 4;

   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_CH1_DISC = 8'h0C;
   localparam logic [7:0] CMD_CH2_DISC = 8'h0D;
   localparam logic [7:0] CMD_CH3_DISC = 8'h0E;
   localparam logic [7:0] CMD_CH4_DISC = 8'h0F;
   localparam logic [7:0] CMD_PWR_STATUS = 8'h10;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CLASS_LSB = 4;
   localparam int DETECT_LSB = 0;
   localparam int PG_LSB = 4;
   localparam int PE_LSB = 0;

   // ------------------------------------------------------------
   // Requested-class codes
   // ------------------------------------------------------------
   localparam logic [3:0] RC_UNKNOWN = 4'h0;
   localparam logic [3:0] RC_CLASS1 = 4'h1;
   localparam logic [3:0] RC_CLASS4 = 4'h4;
   localparam logic [3:0] RC_RSVD_C0 = 4'h5;
   localparam logic [3:0] RC_CLASS0 = 4'h6;
   localparam logic [3:0] RC_OVERCUR = 4'h7;
   localparam logic [3:0] RC_SS_CLASS5 = 4'h8;
   localparam logic [3:0] RC_SS_CLASS8 = 4'hB;
   localparam logic [3:0] RC_LIMITED = 4'hC;
   localparam logic [3:0] RC_DS_CLASS5 = 4'hD;
   localparam logic [3:0] RC_RSVD_E = 4'hE;
   localparam logic [3:0] RC_MISMATCH = 4'hF;

   // ------------------------------------------------------------
   // Detection codes
   // ------------------------------------------------------------
   localparam logic [3:0] DT_UNKNOWN = 4'h0;
   localparam logic [3:0] DT_SHORT = 4'h1;
   localparam logic [3:0] DT_RSVD2 = 4'h2;
   localparam logic [3:0] DT_TOO_LOW = 4'h3;
   localparam logic [3:0] DT_VALID = 4'h4;
   localparam logic [3:0] DT_TOO_HIGH = 4'h5;
   localparam logic [3:0] DT_OPEN = 4'h6;
   localparam logic [3:0] DT_RSVD7 = 4'h7;
   localparam logic [3:0] DT_FET_FAULT = 4'hE;

   // Assigned class for a class 0 signature
   localparam logic [3:0] ASSIGNED_FOR_CLASS0 = 4'h3;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int REPORT_MS = 5;
   localparam int REPORT_CYCLES = REPORT_MS * 1000 * CLK_MHZ;

   typedef struct packed {
      logic [3:0] req_class;
      logic [3:0] detect;
   } disc_t;

   typedef struct packed {
      logic valid;
      logic [3:0] meas_class;
      logic [3:0] detect;
   } class_result_t;

endpackage

// ===== hw/class_report.sv
// Purpose: Maps one raw classification result to the reported requested class
// Assumes: Raw class given as 0..8, with flags from the channel pipeline
// Notes: Pure combinational mapping, registered by the caller
`timescale 1ns/10ps
`default_nettype none
module class_report
   import chan_status_pkg::*;
(
   input wire logic [3:0] raw_class_i,
   input wire logic overcurrent_i,
   input wire logic mismatch_i,
   input wire logic four_pair_ss_i,
   input wire logic four_pair_ds_i,
   input wire logic limited_alloc_i,
   input wire logic single_cls_manual_i,
   output logic [3:0] code_o
);

   always_comb begin
      code_o = RC_UNKNOWN;
      if (overcurrent_i) begin
         code_o = RC_OVERCUR;
      end else if (mismatch_i) begin
         code_o = RC_MISMATCH;
      end else if (limited_alloc_i && raw_class_i >= 4'h4) begin
         code_o = RC_LIMITED;
      end else if (single_cls_manual_i && four_pair_ss_i && raw_class_i == 4'h8) begin
         code_o = RC_DS_CLASS5;
      end else begin
         case (raw_class_i)
            4'h0: code_o = RC_CLASS0;
            4'h1, 4'h2, 4'h3, 4'h4: code_o = raw_class_i;
            4'h5, 4'h6, 4'h7, 4'h8: begin
               if (four_pair_ds_i && raw_class_i == 4'h5) begin
                  code_o = RC_DS_CLASS5;
               end else if (four_pair_ss_i) begin
                  code_o = 4'(raw_class_i + 4'h3);
               end else begin
                  code_o = RC_CLASS4;
               end
            end
            default: code_o = RC_UNKNOWN;
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== hw/chan_status_regs.sv
// Purpose: Channel discovery and power status register bank for one group of four channels
// Assumes: Inputs synchronous to clk_i; register port is a byte command/read strobe
// Notes: All registers read-only; writes ignored
`timescale 1ns/10ps
`default_nettype none
module chan_status_regs
   import chan_status_pkg::*;
#(
   parameter int CHANNELS = NUM_CH,
   parameter int REPORT_DELAY = REPORT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // Channel state
   input wire logic [3:0] chan_on_i,
   input wire logic [3:0] drain_sense_pin_i,
   input wire logic [3:0] cls_done_i,
   input wire logic [15:0] raw_class_i,
   input wire logic [15:0] raw_detect_i,
   input wire logic [3:0] cls_overcur_i,
   input wire logic [3:0] cls_mismatch_i,
   input wire logic [3:0] limited_alloc_i,
   input wire logic [3:0] manual_mode_i,
   input wire logic [3:0] cls_enable_i,
   // One bit per pair: channels 1/2 and 3/4 wired as four-pair
   input wire logic [1:0] four_pair_i,
   input wire logic [1:0] dual_sig_i,
   // Events and assigned class
   output logic [3:0] class_complete_event_o,
   output logic [3:0] power_enable_change_event_o,
   output logic [3:0] power_good_change_event_o,
   output logic [15:0] assigned_class_o
);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   // Pair decoding and the read map are fixed to four channels
   if (CHANNELS != 4) begin : g_bad_channels
      $error("chan_status_regs serves exactly four channels");
   end
   // Report counter is 24 bits; longer delays would wrap
   if (REPORT_DELAY < 1 || REPORT_DELAY > 32'h01000000) begin : g_bad_delay
      $error("REPORT_DELAY must lie between 1 and 16777216 cycles");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [1:0] partner(input logic [1:0] ch);
      partner = {ch[1], ~ch[0]};
   endfunction

   function automatic logic [3:0] nib(input logic [15:0] v, input logic [1:0] ch);
      nib = v[ch*4 +: 4];
   endfunction

   // Pair bit 0 covers channels 1/2, bit 1 channels 3/4
   function automatic logic [3:0] four_pair_mask(input logic [1:0] fp, input logic [1:0] ds,
                                                 input logic dual);
      logic [1:0] hit;
      hit = fp & (dual ? ds : ~ds);
      four_pair_mask = {{2{hit[1]}}, {2{hit[0]}}};
   endfunction

   // One pair change instead of two, so the host sees one interrupt
   // Single signature needs both
   function automatic logic [3:0] good_mask(input logic [3:0] low, input logic [3:0] ss);
      logic [3:0] both;
      both = {{2{low[3] & low[2]}}, {2{low[1] & low[0]}}};
      good_mask = (ss & both) | (~ss & low);
   endfunction

   // Unlisted codes read as unknown, never as a made-up status
   // Listed detection codes only
   function automatic logic [3:0] detect_code(input logic [3:0] raw);
      case (raw)
         DT_UNKNOWN, DT_SHORT, DT_RSVD2, DT_TOO_LOW, DT_VALID,
         DT_TOO_HIGH, DT_OPEN, DT_RSVD7, DT_FET_FAULT: detect_code = raw;
         default: detect_code = DT_UNKNOWN;
      endcase
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   disc_t disc_ff [4];
   logic [3:0] pg_ff;
   logic [3:0] pe_ff;
   logic [3:0] drain_low_ff;
   logic [3:0] class_complete_event_ff;
   logic [3:0] pec_ff;
   logic [3:0] pgc_ff;
   logic [15:0] assigned_ff;
   // Pending result per channel, shown when its delay runs out
   logic [3:0] pend_ff;
   disc_t pend_val_ff [4];
   logic [23:0] wait_ff [4];
   // Register port side
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic [15:0] code_w;
   logic [3:0] ss_w;
   logic [3:0] ds_w;
   logic [3:0] good_w;
   logic [3:0] nxt_pg;

   // One-hot delay states per channel
   typedef enum logic [2:0] {
      WAIT_IDLE = 3'b001,
      WAIT_RUN = 3'b010,
      WAIT_DONE = 3'b100
   } wait_state_t;

   wait_state_t wst_ff [4];

   // ------------------------------------------------------------
   // Class mapping per channel
   // ------------------------------------------------------------
   assign ss_w = four_pair_mask(four_pair_i, dual_sig_i, 1'b0);
   assign ds_w = four_pair_mask(four_pair_i, dual_sig_i, 1'b1);

   for (genvar g = 0; g < 4; g++) begin : g_map
      class_report u_map (
         .raw_class_i(raw_class_i[g*4 +: 4]),
         .overcurrent_i(cls_overcur_i[g]),
         .mismatch_i(cls_mismatch_i[g]),
         .four_pair_ss_i(ss_w[g]),
         .four_pair_ds_i(ds_w[g]),
         .limited_alloc_i(limited_alloc_i[g]),
         .single_cls_manual_i(manual_mode_i[g] && (cls_enable_i[g] != cls_enable_i[g ^ 1])),
         .code_o(code_w[g*4 +: 4])
      );
   end

   // ------------------------------------------------------------
   // Report scheduling
   // ------------------------------------------------------------
   // Result shown REPORT_DELAY + 1 cycles after the done pulse is taken, by default just past the 5ms window; the
   // wait lets firmware settle both halves of a four-pair port.
   for (genvar g = 0; g < 4; g++) begin : g_sched
      logic [1:0] me;
      logic src_hit;
      logic [1:0] src;
      assign me = 2'(g);
      assign src_hit = cls_done_i[g] || (ss_w[g] && cls_done_i[partner(me)]);
      assign src = cls_done_i[g] ? me : partner(me);

      // A result arriving while one is counting is dropped
      always_ff @(posedge clk_i) begin
         if (rst_i || !chan_on_i[g] && !cls_enable_i[g]) begin
            wst_ff[g] <= WAIT_IDLE;
            wait_ff[g] <= 24'h000000;
            pend_ff[g] <= 1'b0;
            pend_val_ff[g] <= '0;
         end else begin
            case (wst_ff[g])
               WAIT_IDLE: begin
                  pend_ff[g] <= 1'b0;
                  if (src_hit) begin
                     pend_val_ff[g].req_class <= nib(code_w, src);
                     pend_val_ff[g].detect <= detect_code(nib(raw_detect_i, src));
                     wait_ff[g] <= 24'(REPORT_DELAY - 1);
                     wst_ff[g] <= WAIT_RUN;
                  end
               end
               WAIT_RUN: begin
                  if (wait_ff[g] == 24'h000000) begin
                     pend_ff[g] <= 1'b1;
                     wst_ff[g] <= WAIT_DONE;
                  end else begin
                     wait_ff[g] <= wait_ff[g] - 24'h000001;
                  end
               end
               WAIT_DONE: begin
                  pend_ff[g] <= 1'b0;
                  wst_ff[g] <= WAIT_IDLE;
               end
               default: wst_ff[g] <= WAIT_IDLE;
            endcase
         end
      end

      // Result survives classification before power-on; only full off clears
      // Clear when off with classification disabled
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            disc_ff[g] <= '0;
         end else if (!chan_on_i[g] && !cls_enable_i[g]) begin
            disc_ff[g] <= '0;
         end else if (pend_ff[g]) begin
            disc_ff[g] <= pend_val_ff[g];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            class_complete_event_ff[g] <= 1'b0;
         end else begin
            class_complete_event_ff[g] <= cls_done_i[g];
         end
      end

      // Assigned class shows only while powered
      // Class 0 assigned as class 3
      always_ff @(posedge clk_i) begin
         if (rst_i || !chan_on_i[g]) begin
            assigned_ff[g*4 +: 4] <= 4'h0;
         end else if (disc_ff[g].req_class == RC_CLASS0 || disc_ff[g].req_class == RC_RSVD_C0) begin
            assigned_ff[g*4 +: 4] <= ASSIGNED_FOR_CLASS0;
         end else begin
            assigned_ff[g*4 +: 4] <= disc_ff[g].req_class;
         end
      end
   end

   // ------------------------------------------------------------
   // Power status
   // ------------------------------------------------------------
   // Drain low seen during turn-on; held so the partner can catch up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drain_low_ff <= 4'h0;
      end else begin
         drain_low_ff <= chan_on_i & (drain_low_ff | ~drain_sense_pin_i);
      end
   end

   assign good_w = good_mask(drain_low_ff, ss_w);
   assign nxt_pg = chan_on_i & (pg_ff | good_w);

   for (genvar g = 0; g < 4; g++) begin : g_pwr

      always_ff @(posedge clk_i) begin
         if (rst_i || !chan_on_i[g]) begin
            pg_ff[g] <= 1'b0;
         end else if (good_w[g]) begin
            pg_ff[g] <= 1'b1;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pe_ff[g] <= 1'b0;
         end else begin
            pe_ff[g] <= chan_on_i[g];
         end
      end
   end

   // ------------------------------------------------------------
   // Change events
   // ------------------------------------------------------------
   // Enable change seen the edge after the on level moves
   // Change events per channel
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pec_ff <= 4'h0;
         pgc_ff <= 4'h0;
      end else begin
         pec_ff <= pe_ff ^ chan_on_i;
         // Same next value as pg_ff, so flag and event move on one edge
         pgc_ff <= pg_ff ^ nxt_pg;
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   // A write in the same cycle blocks the read; wdata_i is never used
   // Read data holds until the next accepted read
   // Reads only; writes dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= REG_RESET;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= rd_i && !wr_i;
         if (rd_i && !wr_i) begin
            case (cmd_i)
               CMD_CH1_DISC: rdata_ff <= disc_ff[0];
               CMD_CH2_DISC: rdata_ff <= disc_ff[1];
               CMD_CH3_DISC: rdata_ff <= disc_ff[2];
               CMD_CH4_DISC: rdata_ff <= disc_ff[3];
               CMD_PWR_STATUS: rdata_ff <= {pg_ff, pe_ff};
               default: rdata_ff <= REG_RESET;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;
   assign class_complete_event_o = class_complete_event_ff;
   assign power_enable_change_event_o = pec_ff;
   assign power_good_change_event_o = pgc_ff;
   assign assigned_class_o = assigned_ff;

endmodule
`default_nettype wire

// ===== verification/chan_status_props.sv
// Purpose: Port checks for the status register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every chan_status_regs instance
`timescale 1ns/10ps
`default_nettype none
module chan_status_props
   import chan_status_pkg::*;
#(
   parameter int REPORT_DELAY = REPORT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic [3:0] chan_on_i,
   input wire logic [3:0] cls_enable_i,
   input wire logic [3:0] cls_done_i,
   input wire logic [3:0] class_complete_event_o,
   input wire logic [3:0] power_good_change_event_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_ok;
   logic off4;
   assign rd_ok = rd_i && !wr_i;
   assign off4 = !chan_on_i[3] && !cls_enable_i[3];

   a_read_answer: assert property (rd_ok |=> rvalid_o) else $error("read not answered");
   a_no_stray: assert property (!rd_ok |=> !rvalid_o) else $error("answer without read");
   a_data_holds: assert property (!rvalid_o |-> $stable(rdata_o)) else $error("read data moved");
   a_unmapped_zero: assert property ((rd_ok && !(cmd_i inside {[8'h0C:8'h10]})) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_pe_follows: assert property ((rd_ok && cmd_i == CMD_PWR_STATUS && !$past(rst_i)) |=>
      rdata_o[3:0] == $past(chan_on_i, 2)) else $error("enable flags wrong");
   a_pg_needs_on: assert property ((rvalid_o && $past(cmd_i) == CMD_PWR_STATUS) |->
      (rdata_o[7:4] & ~rdata_o[3:0]) == 4'h0) else $error("good flag while off");
   a_cls_event: assert property (!$past(rst_i) |-> class_complete_event_o == $past(cls_done_i))
      else $error("class event mismatch");
   a_off_clears: assert property ((rd_ok && cmd_i == CMD_CH4_DISC && off4 && $past(off4) && $past(off4, 2))
      |=> rdata_o == 8'h00) else $error("off channel kept result");
   c_pwr_read: cover property (rd_ok && cmd_i == CMD_PWR_STATUS);
   c_cls_event: cover property (class_complete_event_o != 4'h0);
   c_pg_event: cover property (power_good_change_event_o != 4'h0);
endmodule
bind chan_status_regs chan_status_props #(.REPORT_DELAY(REPORT_DELAY)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i), .wr_i(wr_i), .cmd_i(cmd_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .chan_on_i(chan_on_i), .cls_enable_i(cls_enable_i), .cls_done_i(cls_done_i),
   .class_complete_event_o(class_complete_event_o), .power_good_change_event_o(power_good_change_event_o)
);
`default_nettype wire

// ===== verification/host_reader.sv
// Purpose: Host side of the command/read register port
// Assumes: Answer comes in the cycle after the taken edge
// Notes: Released strobes drop low; command and write-data lines show inverted values, never the old ones
`timescale 1ns/10ps
`default_nettype none
module host_reader (
   input wire logic clk_i,
   input wire logic rvalid_i,
   input wire logic [7:0] rdata_i,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] cmd_o,
   output logic [7:0] wdata_o
);
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      cmd_o = 8'h00;
      wdata_o = 8'h00;
   end
   // ------------------------------------------------------------
   // One access, read or write
   // ------------------------------------------------------------
   task automatic access(input logic w, input logic [7:0] c, input logic [7:0] wd,
                         output logic [7:0] d, output logic ok);
      @(posedge clk_i);
      #1;
      rd_o = !w;
      wr_o = w;
      cmd_o = c;
      wdata_o = wd;
      @(posedge clk_i);
      #1;
      // Answer stands in the cycle after the taken edge
      ok = rvalid_i;
      d = rdata_i;
      rd_o = 1'b0;
      wr_o = 1'b0;
      cmd_o = ~c;
      wdata_o = ~wd;
   endtask
endmodule
`default_nettype wire

// ===== verification/channel_discovery_power_status_tb_top.sv
// Purpose: Self-checking bench for the status register bank
// Assumes: Shortened report delay, inputs driven 1 ns after the edge
// Notes: Seeded xorshift picks classes, detections and channel states
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin n_tests++; if ((got) !== (exp)) begin err_count++; \
   $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module channel_discovery_power_status_tb_top
   import chan_status_pkg::*;
;
   localparam int RD = 10;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rd_i, wr_i, rvalid_o, ok;
   logic [7:0] cmd_i, wdata_i, rdata_o, d;
   logic [3:0] on, drain, done, oc, mm, lim, man, cen, cce, pec, pgc, pec_seen, pgc_seen;
   logic [3:0] raw, det, code, pgm, old_on, old_pg;
   logic [15:0] requested_class_field, rdet, asg;
   logic [1:0] fp, dual;
   logic [3:0] dets [9];
   logic [31:0] seed = 32'hFFE5;
   int err_count = 0;
   int n_tests = 0;
   int k, sel;

   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      pec_seen |= pec;
      pgc_seen |= pgc;
   end

   chan_status_regs #(.REPORT_DELAY(RD)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i), .wr_i(wr_i), .cmd_i(cmd_i), .wdata_i(wdata_i),
      .rdata_o(rdata_o), .rvalid_o(rvalid_o), .chan_on_i(on), .drain_sense_pin_i(drain),
      .cls_done_i(done), .raw_class_i(requested_class_field), .raw_detect_i(rdet), .cls_overcur_i(oc),
      .cls_mismatch_i(mm), .limited_alloc_i(lim), .manual_mode_i(man), .cls_enable_i(cen),
      .four_pair_i(fp), .dual_sig_i(dual), .class_complete_event_o(cce),
      .power_enable_change_event_o(pec), .power_good_change_event_o(pgc), .assigned_class_o(asg)
   );
   host_reader u_host (.clk_i(clk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o), .rd_o(rd_i),
      .wr_o(wr_i), .cmd_o(cmd_i), .wdata_o(wdata_i));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [3:0] exp_class(input logic [3:0] r, input logic o, m, l, ss, m1);
      if (o) return RC_OVERCUR;
      if (m) return RC_MISMATCH;
      if (l && r >= 4'h4) return RC_LIMITED;
      if (r == 4'h0) return RC_CLASS0;
      if (r <= 4'h4) return r;
      // Without a four-pair pairing the top class is 4
      if (!ss) return RC_CLASS4;
      if (m1 && r == 4'h8) return RC_DS_CLASS5;
      return r + 4'h3;
   endfunction
   task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
      u_host.access(1'b0, c, 8'h00, d, ok);
      `CHK("rvalid", 1'b1, ok)
      `CHK("rdata", e, d)
   endtask
   task automatic classify(input int ch, input logic [3:0] r, input logic [3:0] dt);
      @(posedge clk_i);
      #1;
      requested_class_field[ch*4+:4] = r;
      rdet[ch*4+:4] = dt;
      done[ch] = 1'b1;
      @(posedge clk_i);
      #1;
      done = 4'h0;
      `CHK("cls_event", 4'h1 << ch, cce)
      repeat (RD + 4) @(posedge clk_i);
   endtask
   task automatic power_step(input logic [3:0] n_on, input logic [3:0] low);
      @(posedge clk_i);
      #1;
      old_on = on;
      old_pg = pgm;
      on = n_on;
      drain = ~low;
      pec_seen = 4'h0;
      pgc_seen = 4'h0;
      pgm = (pgm & n_on) | (n_on & low);
      repeat (5) @(posedge clk_i);
      #1;
   endtask
   task automatic wrap_up();
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      dets = '{DT_UNKNOWN, DT_SHORT, DT_RSVD2, DT_TOO_LOW, DT_VALID, DT_TOO_HIGH, DT_OPEN, DT_RSVD7, DT_FET_FAULT};
      {on, done, oc, mm, lim, man, fp, dual, pgm, pec_seen, pgc_seen} = '0;
      drain = 4'hF;
      cen = 4'hF;
      requested_class_field = 16'h0000;
      rdet = 16'h0000;
      repeat (10) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      for (int i = 0; i < 6; i++) rd_chk(8'(8'h0C + i), 8'h00);
      // Powered, so the assigned class shows
      on = 4'hF;
      for (int n = 0; n < 16; n++) begin
         k = int'(rnd() % 4);
         raw = 4'(rnd() % 5);
         det = dets[rnd() % 9];
         sel = int'(rnd() % 4);
         oc[k] = (sel == 1);
         mm[k] = (sel == 2);
         lim[k] = (sel == 3);
         classify(k, raw, det);
         code = exp_class(raw, oc[k], mm[k], lim[k], 1'b0, 1'b0);
         rd_chk(8'(8'h0C + k), {code, det});
         `CHK("assigned", (code == RC_CLASS0) ? ASSIGNED_FOR_CLASS0 : code, asg[k*4+:4])
      end
      {oc, mm, lim} = '0;
      on = 4'h0;
      fp = 2'b01;
      for (int r = 5; r < 9; r++) begin
         classify(0, 4'(r), DT_VALID);
         code = exp_class(4'(r), 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
         rd_chk(CMD_CH1_DISC, {code, DT_VALID});
         u_host.access(1'b0, CMD_CH2_DISC, 8'h00, d, ok);
         `CHK("partner_class", code, d[7:4])
      end
      man[0] = 1'b1;
      cen[1] = 1'b0;
      classify(0, 4'h8, DT_VALID);
      rd_chk(CMD_CH1_DISC, {RC_DS_CLASS5, DT_VALID});
      man[0] = 1'b0;
      cen[1] = 1'b1;
      fp = 2'b10;
      dual = 2'b10;
      classify(2, 4'h3, DT_VALID);
      classify(3, 4'h2, DT_TOO_HIGH);
      rd_chk(CMD_CH3_DISC, {4'h3, DT_VALID});
      rd_chk(CMD_CH4_DISC, {4'h2, DT_TOO_HIGH});
      u_host.access(1'b1, CMD_CH3_DISC, 8'hA5, d, ok);
      `CHK("write_answer", 1'b0, ok)
      rd_chk(CMD_CH3_DISC, {4'h3, DT_VALID});
      cen[3] = 1'b0;
      repeat (3) @(posedge clk_i);
      rd_chk(CMD_CH4_DISC, 8'h00);
      cen[3] = 1'b1;
      fp = 2'b00;
      dual = 2'b00;
      for (int n = 0; n < 8; n++) begin
         power_step(4'(rnd()), 4'(rnd()));
         rd_chk(CMD_PWR_STATUS, {pgm, on});
         `CHK("pe_event", old_on ^ on, pec_seen)
         `CHK("pg_event", old_pg ^ pgm, pgc_seen)
      end
      power_step(4'h0, 4'hF);
      fp = 2'b01;
      power_step(4'h1, 4'hF);
      rd_chk(CMD_PWR_STATUS, 8'h01);
      power_step(4'h3, 4'hF);
      rd_chk(CMD_PWR_STATUS, 8'h33);
      wrap_up();
   end
endmodule
`default_nettype wire
